//--- design/twmh_pkg.sv
/*
 * Package for the two-wire master task and event hub: register offsets,
 * field positions, reset values, the carrier structs for tasks and events
 * and the address decode helpers.
 * Assumes a 12-bit APB byte address and a 256-channel event fabric.
 */
package twmh_pkg;
   // ==========================================================
   // Register byte offsets.
   localparam logic [11:0] OFS_RX_START = 12'h000;   // Receive start trigger.
   localparam logic [11:0] OFS_TX_START = 12'h008;   // Transmit start trigger.
   localparam logic [11:0] OFS_HALT = 12'h014;       // Stop trigger.
   localparam logic [11:0] OFS_PAUSE = 12'h01c;      // Suspend trigger.
   localparam logic [11:0] OFS_CONTINUE = 12'h020;   // Resume trigger.
   localparam logic [11:0] OFS_LINKS = 12'h200;      // Event to task links.
   localparam logic [11:0] OFS_IRQ_STAT = 12'h310;   // Sticky interrupt status.
   localparam logic [11:0] OFS_IRQ_MASK = 12'h314;   // Interrupt mask.
   localparam logic [11:0] OFS_STATE = 12'h318;      // Paused state.
   // Task order: receive start, transmit start, stop, suspend, resume.
   localparam int NUM_TASKS = 5;
   localparam logic [11:0] TASK_OFS [NUM_TASKS] =
      '{OFS_RX_START, OFS_TX_START, OFS_HALT, OFS_PAUSE, OFS_CONTINUE};
   localparam logic [11:0] SUB_OFS [NUM_TASKS] =
      '{12'h080, 12'h088, 12'h094, 12'h09c, 12'h0a0};
   // Event order: stopped, error, suspended, rx begun, tx begun, final rx, final tx.
   localparam int NUM_EVTS = 7;
   localparam logic [11:0] FLAG_OFS [NUM_EVTS] =
      '{12'h104, 12'h124, 12'h148, 12'h14c, 12'h150, 12'h15c, 12'h160};
   localparam logic [11:0] PUB_OFS [NUM_EVTS] =
      '{12'h184, 12'h1a4, 12'h1c8, 12'h1cc, 12'h1d0, 12'h1dc, 12'h1e0};
   // ==========================================================
   // Field positions and reset values.
   localparam int CHAN_W = 8;                 // Channel index width, 0 to 255.
   localparam int EN_BIT = 31;                // Subscribe and publish enable.
   localparam int LNK_TX_RX = 0;              // Final tx to receive start.
   localparam int LNK_TX_PAUSE = 1;           // Final tx to suspend.
   localparam int LNK_TX_HALT = 2;            // Final tx to stop.
   localparam int LNK_RX_TX = 3;              // Final rx to transmit start.
   localparam int LNK_RX_HALT = 5;            // Final rx to stop.
   localparam logic [5:0] LINKS_RESET = 6'h00;
   localparam logic [8:0] CFG_RESET = 9'h000; // Enable plus channel index.
   // ==========================================================
   // Carrier structs.
   typedef struct packed {
      logic final_tx;
      logic final_rx;
      logic tx_begun;
      logic rx_begun;
      logic paused;
      logic fault;
      logic halted;
   } twmh_evt_t;
   typedef struct packed {
      logic resume;
      logic suspend;
      logic stop;
      logic transmit_start_task;
      logic receive_start_task;
   } twmh_task_t;
   // ==========================================================
   // Address decode helpers.

   // Returns true when the address matches one of the subscription offsets.
   function automatic logic is_sub(input logic [11:0] a);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_TASKS; i++)
      begin
         hit = hit | (a == SUB_OFS[i]);
      end
      return hit;
   endfunction

   // Returns true when the address is any mapped register.
   function automatic logic is_mapped(input logic [11:0] a);
      logic hit;
      hit = is_sub(a) | (a == OFS_LINKS) | (a == OFS_IRQ_STAT);
      hit = hit | (a == OFS_IRQ_MASK) | (a == OFS_STATE);
      for (int i = 0; i < NUM_TASKS; i++)
      begin
         hit = hit | (a == TASK_OFS[i]);
      end
      for (int i = 0; i < NUM_EVTS; i++)
      begin
         hit = hit | (a == FLAG_OFS[i]) | (a == PUB_OFS[i]);
      end
      return hit;
   endfunction
endpackage : twmh_pkg

//--- design/twmh_hub.sv
/*
 * Task, event, subscription, publication and shortcut hub of a two-wire
 * master, an APB slave with zero wait states. Assumes the protocol engine
 * takes one-cycle task pulses and reports one-cycle event pulses, and that
 * the event fabric carries one-cycle pulses on 256 channels.
 */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Suspend trigger write pauses the transfer.
// - Subscription holds eight-bit channel index.
// - Subscription enable bit gates channel activity.
// - Enabled resume subscription fires resume task.
// - Suspended flag rises once traffic halted.
// - Final receive byte raises its flag.
// - Final transmit byte raises its flag.
// - Enabled publish signals event on channel.
// - Final tx link starts receive.
// - Final tx link suspends.
// - Final tx link stops.
// - Final rx link starts transmit.
// - Final rx link stops; links reset off.
module twmh_hub
   import twmh_pkg::*;
#(
   parameter int FAB_CHANS = 256
)
(
   // APB slave.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Protocol engine.
   input wire twmh_evt_t evt_in,
   output twmh_task_t task_out,
   // Event fabric.
   input wire logic [FAB_CHANS-1:0] fabric_in,
   output logic [FAB_CHANS-1:0] fabric_out,
   // Interrupt.
   output logic irq
);
   // ==========================================================
   // Storage.
   logic [8:0] sub_reg [NUM_TASKS];      // Enable and channel per task.
   logic [8:0] pub_reg [NUM_EVTS];       // Enable and channel per event.
   logic [NUM_EVTS-1:0] flag_reg;        // Event flags.
   logic [NUM_EVTS-1:0] irq_stat_reg;    // Sticky interrupt status.
   logic [NUM_EVTS-1:0] irq_mask_reg;    // Interrupt mask.
   logic [5:0] links_reg;                // Event to task links.
   logic paused_reg;                     // Traffic currently suspended.
   logic [NUM_TASKS-1:0] task_reg;       // Registered task pulses.
   logic [NUM_TASKS-1:0] task_next;      // Next task pulses.
   logic [FAB_CHANS-1:0] pub_out_reg;    // Registered publish pulses.
   logic [FAB_CHANS-1:0] pub_out_next;   // Next publish pulses.
   logic [31:0] prdata_reg;              // Read data.
   logic [31:0] rd_next;                 // Read data of the addressed register.
   logic [NUM_EVTS-1:0] ev;              // Event pulses as a vector.
   logic wr_en;                          // Write taken this edge.
   logic rd_en;                          // Read taken this edge.

   assign ev = evt_in;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   // The slave never inserts wait states.
   assign pready = 1'b1;
   // Unmapped addresses answer with an error in the access phase.
   assign pslverr = psel & penable & ~is_mapped(paddr);
   assign prdata = prdata_reg;
   assign task_out = task_reg;
   assign fabric_out = pub_out_reg;
   // The interrupt stays high while any unmasked status bit is set.
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ==========================================================
   // Configuration registers.

   // Subscription, publication and link registers written by software.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NUM_TASKS; i++)
         begin
            sub_reg[i] <= CFG_RESET;
         end
         for (int i = 0; i < NUM_EVTS; i++)
         begin
            pub_reg[i] <= CFG_RESET;
         end
         links_reg <= LINKS_RESET;
         irq_mask_reg <= '0;
      end
      else if (wr_en)
      begin
         for (int i = 0; i < NUM_TASKS; i++)
         begin
            if (paddr == SUB_OFS[i])
            begin
               // Channel index and enable bit are kept side by side.
               sub_reg[i] <= {pwdata[EN_BIT], pwdata[CHAN_W-1:0]};
            end
         end
         for (int i = 0; i < NUM_EVTS; i++)
         begin
            if (paddr == PUB_OFS[i])
            begin
               pub_reg[i] <= {pwdata[EN_BIT], pwdata[CHAN_W-1:0]};
            end
         end
         if (paddr == OFS_LINKS)
         begin
            links_reg <= pwdata[5:0];
         end
         if (paddr == OFS_IRQ_MASK)
         begin
            irq_mask_reg <= pwdata[NUM_EVTS-1:0];
         end
      end
   end

   // ==========================================================
   // Task pulses: software writes, subscriptions and links.

   // Gathers every source of each task into one pulse.
   always_comb
   begin
      task_next = '0;
      for (int i = 0; i < NUM_TASKS; i++)
      begin
         // Only a write of one triggers a task.
         if (wr_en && paddr == TASK_OFS[i] && pwdata[0])
         begin
            task_next[i] = 1'b1;
         end
         // A disabled subscription ignores its channel.
         if (sub_reg[i][8] && fabric_in[sub_reg[i][7:0]])
         begin
            task_next[i] = 1'b1;
         end
      end
      if (ev[6])
      begin
         task_next[0] = task_next[0] | links_reg[LNK_TX_RX];
         task_next[3] = task_next[3] | links_reg[LNK_TX_PAUSE];
         task_next[2] = task_next[2] | links_reg[LNK_TX_HALT];
      end
      if (ev[5])
      begin
         task_next[1] = task_next[1] | links_reg[LNK_RX_TX];
         task_next[2] = task_next[2] | links_reg[LNK_RX_HALT];
      end
   end

   // Registers the task pulses toward the engine.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         task_reg <= '0;
      end
      else
      begin
         task_reg <= task_next;
      end
   end

   // Tracks whether traffic is suspended; resume picks up where it paused.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         paused_reg <= 1'b0;
      end
      else if (ev[2])
      begin
         paused_reg <= 1'b1;
      end
      else if (task_reg[4] || ev[0])
      begin
         // The engine continues the same transaction with no new start.
         paused_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Event flags and interrupt status.

   // Flags stick until software writes zero; a new event wins the clear.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < NUM_EVTS; i++)
         begin
            if (ev[i])
            begin
               flag_reg[i] <= 1'b1;
            end
            else if (wr_en && paddr == FLAG_OFS[i] && !pwdata[0])
            begin
               flag_reg[i] <= 1'b0;
            end
         end
      end
   end

   // Interrupt status is cleared by a read; a new event wins the clear.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_reg <= '0;
      end
      else if (rd_en && paddr == OFS_IRQ_STAT)
      begin
         // Only the bits handed out by this read are cleared, so none is lost.
         irq_stat_reg <= (irq_stat_reg & ~prdata_reg[NUM_EVTS-1:0]) | ev;
      end
      else
      begin
         irq_stat_reg <= irq_stat_reg | ev;
      end
   end

   // ==========================================================
   // Publication onto the event fabric.

   // Each enabled event drives a pulse on its chosen channel.
   always_comb
   begin
      pub_out_next = '0;
      for (int i = 0; i < NUM_EVTS; i++)
      begin
         if (ev[i] && pub_reg[i][8])
         begin
            pub_out_next[pub_reg[i][7:0]] = 1'b1;
         end
      end
   end

   // Registers the fabric pulses.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pub_out_reg <= '0;
      end
      else
      begin
         pub_out_reg <= pub_out_next;
      end
   end

   // ==========================================================
   // Read path.

   // Selects the addressed register; task triggers read as zero.
   always_comb
   begin
      rd_next = '0;
      for (int i = 0; i < NUM_TASKS; i++)
      begin
         if (paddr == SUB_OFS[i])
         begin
            rd_next = {sub_reg[i][8], 23'h000000, sub_reg[i][7:0]};
         end
      end
      for (int i = 0; i < NUM_EVTS; i++)
      begin
         if (paddr == FLAG_OFS[i])
         begin
            rd_next = {31'h00000000, flag_reg[i]};
         end
         if (paddr == PUB_OFS[i])
         begin
            rd_next = {pub_reg[i][8], 23'h000000, pub_reg[i][7:0]};
         end
      end
      if (paddr == OFS_LINKS)
      begin
         rd_next = {26'h0000000, links_reg};
      end
      if (paddr == OFS_IRQ_STAT)
      begin
         rd_next = {25'h0000000, irq_stat_reg};
      end
      if (paddr == OFS_IRQ_MASK)
      begin
         rd_next = {25'h0000000, irq_mask_reg};
      end
      if (paddr == OFS_STATE)
      begin
         rd_next = {31'h00000000, paused_reg};
      end
   end

   // Captures read data in the setup phase so it is steady in access.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= '0;
      end
      else if (psel && !penable && !pwrite)
      begin
         prdata_reg <= rd_next;
      end
   end

   // ==========================================================
   // Assertions and covers.

   a_pause_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == OFS_PAUSE && pwdata[0] |=> task_out.suspend)
      else $error("Suspend write did not pulse suspend task.");

   a_resume_sub: assert property (@(posedge pclk) disable iff (!presetn)
      sub_reg[4][8] && fabric_in[sub_reg[4][7:0]] |=> task_out.resume)
      else $error("Resume subscription did not fire.");

   a_sub_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !sub_reg[4][8] && !(wr_en && paddr == OFS_CONTINUE) |=> !task_out.resume)
      else $error("Disabled subscription fired resume.");

   a_paused_flag: assert property (@(posedge pclk) disable iff (!presetn)
      evt_in.paused |=> flag_reg[2] && paused_reg)
      else $error("Suspended flag not raised.");

   a_final_rx: assert property (@(posedge pclk) disable iff (!presetn)
      evt_in.final_rx |=> flag_reg[5])
      else $error("Final receive flag not raised.");

   a_final_tx: assert property (@(posedge pclk) disable iff (!presetn)
      evt_in.final_tx |=> flag_reg[6])
      else $error("Final transmit flag not raised.");

   a_publish_halt: assert property (@(posedge pclk) disable iff (!presetn)
      evt_in.halted && pub_reg[0][8] |=> fabric_out[$past(pub_reg[0][7:0])])
      else $error("Stopped event not published.");

   a_link_tx_rx: assert property (@(posedge pclk) disable iff (!presetn)
      evt_in.final_tx && links_reg[LNK_TX_RX] |=> task_out.receive_start_task)
      else $error("Final tx link did not start receive.");

   a_link_tx_pause: assert property (@(posedge pclk) disable iff (!presetn)
      evt_in.final_tx && links_reg[LNK_TX_PAUSE] |=> task_out.suspend)
      else $error("Final tx link did not suspend.");

   a_link_tx_halt: assert property (@(posedge pclk) disable iff (!presetn)
      evt_in.final_tx && links_reg[LNK_TX_HALT] |=> task_out.stop)
      else $error("Final tx link did not stop.");

   a_link_rx_tx: assert property (@(posedge pclk) disable iff (!presetn)
      evt_in.final_rx && links_reg[LNK_RX_TX] |=> task_out.transmit_start_task)
      else $error("Final rx link did not start transmit.");

   a_link_rx_halt: assert property (@(posedge pclk) disable iff (!presetn)
      evt_in.final_rx && links_reg[LNK_RX_HALT] |=> task_out.stop)
      else $error("Final rx link did not stop.");

   a_resume_clear: assert property (@(posedge pclk) disable iff (!presetn)
      task_out.resume && !evt_in.paused |=> !paused_reg)
      else $error("Resume did not leave paused state.");

   a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
      flag_reg[0] && !(wr_en && paddr == FLAG_OFS[0]) |=> flag_reg[0])
      else $error("Stopped flag dropped without a write.");

   c_suspend_resume: cover property (@(posedge pclk) disable iff (!presetn)
      evt_in.paused ##[1:20] task_out.resume);

   c_link_chain: cover property (@(posedge pclk) disable iff (!presetn)
      evt_in.final_tx ##1 task_out.receive_start_task);

   c_irq_raise: cover property (@(posedge pclk) disable iff (!presetn)
      !irq ##1 irq);

endmodule // twmh_hub

//--- testbench/twmh_engine_model.sv
/*
 * Behavioural model of the protocol engine behind the task and event hub.
 * Assumes one-cycle task pulses from the hub and bench-driven event injections.
 */
`timescale 1ns/1ps
module twmh_engine_model
   import twmh_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Bench controls.
   input wire logic slow,
   input wire twmh_evt_t inject,
   // Hub side.
   input wire twmh_task_t task_out,
   output twmh_evt_t evt_in
);
   // ==========================================
   // Engine state.
   logic pend_reg; // A suspend is waiting for the next safe point.
   logic [2:0] wait_reg; // Cycles left until that safe point.

   // Answers task pulses with events; a slow engine takes longer to pause.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         evt_in <= '0;
         pend_reg <= 1'b0;
         wait_reg <= 3'h0;
      end
      else
      begin
         evt_in <= inject;
         if (task_out.suspend)
         begin
            pend_reg <= 1'b1;
            wait_reg <= slow ? 3'h6 : 3'h0;
         end
         else if (pend_reg && wait_reg != 3'h0)
            wait_reg <= wait_reg - 3'h1;
         else if (pend_reg)
         begin
            // Traffic has halted only now, so the pause is reported here.
            pend_reg <= 1'b0;
            evt_in.paused <= 1'b1;
         end
         if (task_out.receive_start_task)
            evt_in.rx_begun <= 1'b1;
         if (task_out.transmit_start_task)
            evt_in.tx_begun <= 1'b1;
         if (task_out.stop)
            evt_in.halted <= 1'b1;
      end
   end
endmodule // twmh_engine_model

//--- testbench/twmh_hub_tb.sv
/*
 * Self-checking testbench for the task and event hub, driven over APB.
 * Assumes the package and the engine model are compiled before it.
 */
`timescale 1ns/1ps
module twmh_hub_tb;
   import twmh_pkg::*;
   // ==========================================
   // Signals.
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   twmh_evt_t evt_in;
   twmh_evt_t inject = '0;
   twmh_task_t task_out;
   logic slow = 1'b0;
   logic [255:0] fabric_in = '0;
   logic [255:0] fabric_out;
   logic irq;
   logic clr = 1'b0; // Empties the pulse collectors.
   logic [4:0] t_seen = '0; // Task pulses since the last clear.
   logic [255:0] f_seen = '0; // Fabric pulses since the last clear.
   int error_cnt = 0;
   int compares = 0;

   // Free-running 100 MHz clock.
   always #5 pclk = ~pclk;

   // Collects one-cycle pulses so that a check never misses one.
   always @(posedge pclk)
   begin
      if (clr)
      begin
         t_seen <= '0;
         f_seen <= '0;
      end
      else
      begin
         t_seen <= t_seen | task_out;
         f_seen <= f_seen | fabric_out;
      end
   end

   twmh_hub #(.FAB_CHANS(256)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .evt_in(evt_in), .task_out(task_out),
      .fabric_in(fabric_in), .fabric_out(fabric_out), .irq(irq));
   twmh_engine_model i_eng (.pclk(pclk), .presetn(presetn), .slow(slow), .inject(inject),
      .task_out(task_out), .evt_in(evt_in));

   // ==========================================
   // Shared tasks.
   task automatic stop_test();
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer.
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask
   task automatic arm();
      @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
   endtask
   task automatic settle();
      repeat (4) @(posedge pclk);
   endtask
   task automatic fire(input twmh_evt_t e);
      @(posedge pclk);
      inject <= e;
      @(posedge pclk);
      inject <= '0;
   endtask
   task automatic pulse(input logic [7:0] ch);
      @(posedge pclk);
      fabric_in[ch] <= 1'b1;
      @(posedge pclk);
      fabric_in <= '0;
   endtask
   task automatic flags_clear();
      for (int i = 0; i < NUM_EVTS; i++)
         wr(FLAG_OFS[i], 32'h0);
   endtask

   // ==========================================
   // Scenarios.
   // Reset values and a refused access to an unmapped place.
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      for (int i = 0; i < NUM_TASKS; i++)
         rd_chk(SUB_OFS[i], 32'h0);
      for (int i = 0; i < NUM_EVTS; i++)
         rd_chk(PUB_OFS[i], 32'h0);
      rd_chk(OFS_LINKS, 32'h0);
      apb(1'b0, 12'h3fc, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      apb(1'b1, 12'h3fc, 32'h5, r, e);
      chk({31'h0, e}, 32'h1);
   endtask
   // Every software trigger acts on a one and ignores a zero.
   task automatic t_sw_tasks();
      for (int i = 0; i < NUM_TASKS; i++)
      begin
         arm();
         wr(TASK_OFS[i], 32'h1);
         settle();
         chk({27'h0, t_seen}, 32'h1 << i);
         arm();
         wr(TASK_OFS[i], 32'h0);
         settle();
         chk({27'h0, t_seen}, 32'h0);
         rd_chk(TASK_OFS[i], 32'h0);
      end
      flags_clear();
   endtask
   // A slow engine pauses late; resume continues without a new start.
   task automatic t_pause();
      @(posedge pclk);
      slow <= 1'b1;
      wr(OFS_PAUSE, 32'h1);
      rd_chk(FLAG_OFS[2], 32'h0);
      settle();
      settle();
      rd_chk(FLAG_OFS[2], 32'h1);
      rd_chk(OFS_STATE, 32'h1);
      wr(FLAG_OFS[2], 32'h1);
      rd_chk(FLAG_OFS[2], 32'h1);
      wr(FLAG_OFS[2], 32'h0);
      rd_chk(FLAG_OFS[2], 32'h0);
      arm();
      wr(OFS_CONTINUE, 32'h1);
      settle();
      chk({27'h0, t_seen}, 32'h10);
      rd_chk(OFS_STATE, 32'h0);
      rd_chk(FLAG_OFS[3], 32'h0);
      rd_chk(FLAG_OFS[4], 32'h0);
      wr(OFS_HALT, 32'h1);
      settle();
      rd_chk(FLAG_OFS[0], 32'h1);
      slow <= 1'b0;
      flags_clear();
   endtask
   // Subscriptions at boundary channels, enabled and then disabled.
   task automatic t_subs();
      logic [7:0] ch [NUM_TASKS] = '{8'h00, 8'h01, 8'h80, 8'hfe, 8'hff};
      wr(SUB_OFS[0], 32'hffff_ffff);
      rd_chk(SUB_OFS[0], 32'h8000_00ff);
      for (int i = 0; i < NUM_TASKS; i++)
      begin
         wr(SUB_OFS[i], {1'b1, 23'h0, ch[i]});
         arm();
         pulse(ch[i]);
         settle();
         chk({27'h0, t_seen}, 32'h1 << i);
         wr(SUB_OFS[i], {24'h0, ch[i]});
         arm();
         pulse(ch[i]);
         settle();
         chk({27'h0, t_seen}, 32'h0);
      end
      flags_clear();
   endtask
   // Every event publishes on its own channel only while enabled.
   task automatic t_pubs();
      for (int i = 0; i < NUM_EVTS; i++)
      begin
         wr(PUB_OFS[i], {1'b1, 23'h0, 8'hf9 + 8'(i)});
         arm();
         fire(twmh_evt_t'(7'h1 << i));
         settle();
         chk({31'h0, f_seen === (256'h1 << (249 + i))}, 32'h1);
         wr(PUB_OFS[i], {24'h0, 8'hf9 + 8'(i)});
         arm();
         fire(twmh_evt_t'(7'h1 << i));
         settle();
         chk({31'h0, f_seen === 256'h0}, 32'h1);
      end
      flags_clear();
   endtask
   // Each shortcut fires its task; with the links off nothing follows.
   task automatic t_links();
      int lb [5] = '{LNK_TX_RX, LNK_TX_PAUSE, LNK_TX_HALT, LNK_RX_TX, LNK_RX_HALT};
      logic [4:0] tk [5] = '{5'h01, 5'h08, 5'h04, 5'h02, 5'h04};
      twmh_evt_t ev;
      for (int i = 0; i < 5; i++)
      begin
         ev = (i < 3) ? twmh_evt_t'(7'h40) : twmh_evt_t'(7'h20);
         wr(OFS_LINKS, 32'h1 << lb[i]);
         arm();
         fire(ev);
         settle();
         chk({27'h0, t_seen}, {27'h0, tk[i]});
         rd_chk((i < 3) ? FLAG_OFS[6] : FLAG_OFS[5], 32'h1);
         if (i == 1)
            wr(OFS_CONTINUE, 32'h1);
         wr(OFS_LINKS, 32'h0);
         arm();
         fire(ev);
         settle();
         chk({27'h0, t_seen}, 32'h0);
         flags_clear();
      end
   endtask
   // Masked and unmasked events on the interrupt line.
   task automatic t_irq();
      logic [31:0] r;
      logic e;
      wr(OFS_IRQ_MASK, 32'h40);
      rd_chk(OFS_IRQ_MASK, 32'h40);
      apb(1'b0, OFS_IRQ_STAT, 32'h0, r, e);
      fire(twmh_evt_t'(7'h02));
      settle();
      chk({31'h0, irq}, 32'h0);
      fire(twmh_evt_t'(7'h40));
      settle();
      chk({31'h0, irq}, 32'h1);
      rd_chk(OFS_IRQ_STAT, 32'h42);
      settle();
      chk({31'h0, irq}, 32'h0);
   endtask

   // ==========================================
   // Main sequence and watchdog.
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_sw_tasks();
      t_pause();
      t_subs();
      t_pubs();
      t_links();
      t_irq();
      stop_test();
   end
   initial
   begin
      repeat (30000) @(posedge pclk);
      error_cnt++;
      stop_test();
   end
endmodule // twmh_hub_tb
